// ==== led_grad_pkg.sv ====
package led_grad_pkg;

    // register offsets
    localparam logic [7:0] ADDR_FAULT_FIRST = 8'h02;
    localparam logic [7:0] ADDR_FAULT_LAST = 8'h07;
    localparam logic [7:0] ADDR_GRID_DURATION = 8'h08;
    localparam logic [7:0] ADDR_GRADATION_CONTROL = 8'h09;
    localparam logic [7:0] ADDR_BANK_CONTROL = 8'h0A;
    localparam logic [7:0] ADDR_PAGE_SELECT = 8'h0B;
    localparam logic [7:0] ADDR_GRID_FIRST = 8'h20;
    localparam logic [7:0] ADDR_GRID_LAST = 8'h5F;

    // field positions
    localparam int TIME_UNIT_MSB = 7;
    localparam int TIME_UNIT_LSB = 6;
    localparam int LENGTH_MSB = 5;
    localparam int RUN_BIT = 7;
    localparam int REPEAT_BIT = 6;
    localparam int WRITE_BANK_BIT = 7;
    localparam int EXEC_BANK_BIT = 6;
    localparam int PAGE_BIT = 7;
    localparam int THERMAL_TRIP_BIT = 7;

    // reset values
    localparam logic [7:0] GRID_DURATION_RESET = 8'h00;
    localparam logic [7:0] GRADATION_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BANK_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] GRID_CFG_RESET = 8'h00;

    // fault codes, two bits per channel
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_SHORT = 2'h1;
    localparam logic [1:0] FAULT_OPEN = 2'h2;

    // time unit encodings
    localparam logic [1:0] UNIT_2U5 = 2'h0;
    localparam logic [1:0] UNIT_5U = 2'h1;
    localparam logic [1:0] UNIT_10U = 2'h2;
    localparam logic [1:0] UNIT_20U = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STEP_2U5_NS = 2500;
    localparam int STEP_5U_NS = 5000;
    localparam int STEP_10U_NS = 10000;
    localparam int STEP_20U_NS = 20000;
    localparam logic [9:0] STEP_2U5_CYC = 10'((STEP_2U5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] STEP_5U_CYC = 10'((STEP_5U_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] STEP_10U_CYC = 10'((STEP_10U_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] STEP_20U_CYC = 10'((STEP_20U_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] LAST_GRID = 6'h3F;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_HOLD = 3'b100
    } seq_state_t;

endpackage : led_grad_pkg

// ==== pin_sync_filter.sv ====
`timescale 1ns/10ps
module pin_sync_filter #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pins in, filtered levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;
    logic [WIDTH-1:0] differ;

    // a bit moves only once stages two and three agree
    always_comb begin
        differ = stage2_q ^ stage3_q;
        level_d = (~differ & stage3_q) | (differ & level_q);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            level_q <= '0;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;

endmodule : pin_sync_filter

// ==== led_gradation_fault_control.sv ====
`timescale 1ns/10ps
// Overview of operation
// - on channel, low current flags open while the sequencer runs
// - off channel reports open status zero
// - on channel, high voltage flags short
// - voltage below threshold keeps short bit zero
// - off channel reports short status zero
// - open and short kept as distinct codes
// - overtemperature disables every output channel
// - overtemperature sets thermal trip flag
// - temperature recovery restores outputs, clears flag
// - time unit bits pick grid step
// - grid lasts step times length plus one
// - clearing run stops, returns to grid0
// - setting run starts at grid0
// - repeat zero runs once, holds grid63
// - repeat one wraps to grid0 forever
// - bank control bit 7 picks write bank
// - bank control bit 6 picks executed bank
// - page bit steers paged address range
// - fault codes 00 none, 01, 10
// - fault codes read at 02h to 07h
// - alternate open/short per grid, both in grid63
// - sixty-four grid registers hold group levels
module led_gradation_fault_control #(
    parameter int NUM_CHANNELS = 24,
    parameter int NUM_GRIDS = 64
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // analog side
    input wire logic [NUM_CHANNELS-1:0] chan_on,
    input wire logic [NUM_CHANNELS-1:0] open_cmp,
    input wire logic [NUM_CHANNELS-1:0] short_cmp,
    input wire logic thermal_trip_flag_cmp,
    // outputs
    output logic [NUM_CHANNELS-1:0] led_enable,
    output logic [7:0] grid_group_level,
    output logic [5:0] grid_index,
    output logic sequence_active,
    output logic thermal_trip_flag
);
    localparam int FAULT_BITS = 2 * NUM_CHANNELS;
    logic [NUM_CHANNELS-1:0] s_open;
    logic [NUM_CHANNELS-1:0] s_short;
    logic [0:0] s_hot;
    // comparators arrive from the analog domain, so they are filtered
    pin_sync_filter #(.WIDTH(NUM_CHANNELS)) u_sync_open (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(open_cmp),
        .level_out(s_open)
    );
    pin_sync_filter #(.WIDTH(NUM_CHANNELS)) u_sync_short (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(short_cmp),
        .level_out(s_short)
    );
    pin_sync_filter #(.WIDTH(1)) u_sync_hot (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(thermal_trip_flag_cmp),
        .level_out(s_hot)
    );
    // control registers
    logic [7:0] duration_q, duration_d;
    logic [7:0] grad_ctl_q, grad_ctl_d;
    logic [7:0] bank_ctl_q, bank_ctl_d;
    logic [7:0] page_q, page_d;
    logic [7:0] grid_mem_q [2][NUM_GRIDS];
    logic [7:0] grid_mem_d [2][NUM_GRIDS];
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic in_grid_range;
    logic [5:0] grid_addr;
    logic [FAULT_BITS-1:0] fault_q, fault_d;
    always_comb begin
        duration_d = duration_q;
        grad_ctl_d = grad_ctl_q;
        bank_ctl_d = bank_ctl_q;
        page_d = page_q;
        grid_mem_d = grid_mem_q;
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        in_grid_range = (reg_addr >= led_grad_pkg::ADDR_GRID_FIRST)
            && (reg_addr <= led_grad_pkg::ADDR_GRID_LAST);
        grid_addr = 6'(reg_addr - led_grad_pkg::ADDR_GRID_FIRST);
        if (reg_wr) begin
            case (reg_addr)
                led_grad_pkg::ADDR_GRID_DURATION: duration_d = reg_wdata;
                led_grad_pkg::ADDR_GRADATION_CONTROL: grad_ctl_d = reg_wdata;
                led_grad_pkg::ADDR_BANK_CONTROL: bank_ctl_d = reg_wdata;
                led_grad_pkg::ADDR_PAGE_SELECT: page_d = reg_wdata;
                default: begin
                    // page 1 of the paged range holds nothing in this block
                    if (in_grid_range && !page_q[led_grad_pkg::PAGE_BIT]) begin
                        grid_mem_d[bank_ctl_q[led_grad_pkg::WRITE_BANK_BIT]][grid_addr]
                            = reg_wdata;
                    end
                end
            endcase
        end
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (reg_addr >= led_grad_pkg::ADDR_FAULT_FIRST
                    && reg_addr <= led_grad_pkg::ADDR_FAULT_LAST) begin
                rdata_d = fault_q[8 * (reg_addr - led_grad_pkg::ADDR_FAULT_FIRST) +: 8];
            end else if (reg_addr == led_grad_pkg::ADDR_GRID_DURATION) begin
                rdata_d = duration_q;
            end else if (reg_addr == led_grad_pkg::ADDR_GRADATION_CONTROL) begin
                rdata_d = grad_ctl_q;
            end else if (reg_addr == led_grad_pkg::ADDR_BANK_CONTROL) begin
                rdata_d = bank_ctl_q;
            end else if (reg_addr == led_grad_pkg::ADDR_PAGE_SELECT) begin
                rdata_d = page_q;
            end else if (in_grid_range && !page_q[led_grad_pkg::PAGE_BIT]) begin
                rdata_d = grid_mem_q[bank_ctl_q[led_grad_pkg::WRITE_BANK_BIT]][grid_addr];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // reserved bits come up zero and keep whatever is written to them
            duration_q <= led_grad_pkg::GRID_DURATION_RESET;
            grad_ctl_q <= led_grad_pkg::GRADATION_CONTROL_RESET;
            bank_ctl_q <= led_grad_pkg::BANK_CONTROL_RESET;
            page_q <= led_grad_pkg::PAGE_SELECT_RESET;
            for (int b = 0; b < 2; b++) begin
                for (int g = 0; g < NUM_GRIDS; g++) begin
                    grid_mem_q[b][g] <= led_grad_pkg::GRID_CFG_RESET;
                end
            end
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            duration_q <= duration_d;
            grad_ctl_q <= grad_ctl_d;
            bank_ctl_q <= bank_ctl_d;
            page_q <= page_d;
            grid_mem_q <= grid_mem_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // sequencer
    led_grad_pkg::seq_state_t state_q, state_d;
    logic [9:0] prescale_q, prescale_d;
    logic [5:0] dur_q, dur_d;
    logic [5:0] grid_q, grid_d;
    logic [7:0] level_q, level_d;
    logic run_bit, repeat_bit, step_done, grid_done;
    logic [9:0] step_cycles;
    always_comb begin
        run_bit = grad_ctl_q[led_grad_pkg::RUN_BIT];
        repeat_bit = grad_ctl_q[led_grad_pkg::REPEAT_BIT];
        case (duration_q[led_grad_pkg::TIME_UNIT_MSB:led_grad_pkg::TIME_UNIT_LSB])
            led_grad_pkg::UNIT_2U5: step_cycles = led_grad_pkg::STEP_2U5_CYC;
            led_grad_pkg::UNIT_5U: step_cycles = led_grad_pkg::STEP_5U_CYC;
            led_grad_pkg::UNIT_10U: step_cycles = led_grad_pkg::STEP_10U_CYC;
            led_grad_pkg::UNIT_20U: step_cycles = led_grad_pkg::STEP_20U_CYC;
            default: step_cycles = led_grad_pkg::STEP_2U5_CYC;
        endcase
        step_done = (prescale_q == step_cycles - 10'h001);
        grid_done = step_done && (dur_q == duration_q[led_grad_pkg::LENGTH_MSB:0]);
        state_d = state_q;
        prescale_d = prescale_q;
        dur_d = dur_q;
        grid_d = grid_q;
        case (state_q)
            led_grad_pkg::SEQ_IDLE: begin
                prescale_d = 10'h000;
                dur_d = 6'h00;
                grid_d = 6'h00;
                if (run_bit) begin
                    state_d = led_grad_pkg::SEQ_RUN;
                end
            end
            led_grad_pkg::SEQ_RUN: begin
                prescale_d = step_done ? 10'h000 : prescale_q + 10'h001;
                if (step_done) begin
                    dur_d = grid_done ? 6'h00 : dur_q + 6'h01;
                end
                if (grid_done) begin
                    if (grid_q != led_grad_pkg::LAST_GRID) begin
                        grid_d = grid_q + 6'h01;
                    end else if (repeat_bit) begin
                        grid_d = 6'h00;
                    end else begin
                        state_d = led_grad_pkg::SEQ_HOLD;
                    end
                end
            end
            led_grad_pkg::SEQ_HOLD: begin
                grid_d = led_grad_pkg::LAST_GRID;
            end
            default: begin
                state_d = led_grad_pkg::SEQ_IDLE;
            end
        endcase
        if (!run_bit) begin
            // stopping wins over everything and parks on grid0
            state_d = led_grad_pkg::SEQ_IDLE;
            grid_d = 6'h00;
            dur_d = 6'h00;
            prescale_d = 10'h000;
        end
        level_d = grid_mem_q[bank_ctl_q[led_grad_pkg::EXEC_BANK_BIT]][grid_d];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= led_grad_pkg::SEQ_IDLE;
            prescale_q <= 10'h000;
            dur_q <= 6'h00;
            grid_q <= 6'h00;
            level_q <= 8'h00;
        end else begin
            state_q <= state_d;
            prescale_q <= prescale_d;
            dur_q <= dur_d;
            grid_q <= grid_d;
            level_q <= level_d;
        end
    end

    // fault classification
    logic [NUM_CHANNELS-1:0] enable_q, enable_d;
    logic hot_q, hot_d;
    logic det_open, det_short, sh, op, running;
    always_comb begin
        running = (state_q != led_grad_pkg::SEQ_IDLE);
        sh = 1'b0;
        op = 1'b0;
        // stopped: only short can be seen; running: alternate, both on grid63
        det_open = running && (grid_q == led_grad_pkg::LAST_GRID || !grid_q[0]);
        det_short = !running || grid_q == led_grad_pkg::LAST_GRID || grid_q[0];
        hot_d = s_hot[0];
        // chan_on is untouched, so recovery gives back the same outputs
        enable_d = s_hot[0] ? '0 : chan_on;
        fault_d = fault_q;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            sh = det_short ? s_short[i] : fault_q[2 * i];
            op = det_open ? s_open[i] : fault_q[2 * i + 1];
            if (!enable_q[i]) begin
                fault_d[2 * i +: 2] = led_grad_pkg::FAULT_NONE;
            end else if (sh) begin
                // short outranks open so code 11 cannot form
                fault_d[2 * i +: 2] = led_grad_pkg::FAULT_SHORT;
            end else if (op) begin
                fault_d[2 * i +: 2] = led_grad_pkg::FAULT_OPEN;
            end else begin
                fault_d[2 * i +: 2] = led_grad_pkg::FAULT_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_q <= '0;
            enable_q <= '0;
            hot_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
            enable_q <= enable_d;
            hot_q <= hot_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign led_enable = enable_q;
    assign grid_group_level = level_q;
    assign grid_index = grid_q;
    assign sequence_active = running;
    assign thermal_trip_flag = hot_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic dne_any;
    always_comb begin
        dne_any = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            dne_any = dne_any | (fault_q[2 * i] & fault_q[2 * i + 1]);
        end
    end
    sequence s_last_grid_ends;
        state_q == led_grad_pkg::SEQ_RUN && grid_done && grid_q == led_grad_pkg::LAST_GRID;
    endsequence
    sequence s_holding;
        state_q == led_grad_pkg::SEQ_HOLD && grid_q == led_grad_pkg::LAST_GRID;
    endsequence
    sequence s_start;
        state_q == led_grad_pkg::SEQ_IDLE && run_bit;
    endsequence
    // channel 5 is the enabled one of the two the bench opens; a held short bit would outrank open
    property p_open_flag;
        enable_q[5] && det_open && s_open[5] && !fault_q[10] && !det_short
            |=> fault_q[11:10] == led_grad_pkg::FAULT_OPEN;
    endproperty
    a_open_flag: assert property (p_open_flag) else $error("open not flagged");
    property p_off_clear;
        !enable_q[0] |=> fault_q[1:0] == led_grad_pkg::FAULT_NONE;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("off channel faulted");
    property p_short_flag;
        enable_q[0] && det_short && s_short[0] |=> fault_q[1:0] == led_grad_pkg::FAULT_SHORT;
    endproperty
    a_short_flag: assert property (p_short_flag) else $error("short not flagged");
    property p_short_low;
        det_short && !s_short[0] |=> !fault_q[0];
    endproperty
    a_short_low: assert property (p_short_low) else $error("short bit set wrongly");
    property p_no_dne;
        !dne_any;
    endproperty
    a_no_dne: assert property (p_no_dne) else $error("fault code 11 seen");
    property p_hot_off;
        thermal_trip_flag |-> led_enable == '0;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("output on while hot");
    property p_cool_restore;
        !s_hot[0] |=> !thermal_trip_flag && led_enable == $past(chan_on);
    endproperty
    a_cool_restore: assert property (p_cool_restore) else $error("outputs not restored");
    property p_stop;
        !run_bit |=> state_q == led_grad_pkg::SEQ_IDLE && grid_q == 6'h00;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not return to grid0");
    property p_start;
        s_start |=> state_q == led_grad_pkg::SEQ_RUN && grid_q == 6'h00;
    endproperty
    a_start: assert property (p_start) else $error("start not at grid0");
    property p_one_shot;
        s_last_grid_ends ##0 !repeat_bit && run_bit |=> s_holding ##1 (s_holding or !run_bit);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one shot did not hold");
    property p_repeat;
        s_last_grid_ends ##0 repeat_bit && run_bit |=> grid_q == 6'h00
            && state_q == led_grad_pkg::SEQ_RUN;
    endproperty
    a_repeat: assert property (p_repeat) else $error("recurrence did not wrap");
    property p_advance;
        state_q == led_grad_pkg::SEQ_RUN && run_bit && grid_done
            && grid_q != led_grad_pkg::LAST_GRID |=> grid_q == $past(grid_q) + 6'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("grid did not advance");
    property p_both_in_last;
        grid_q == led_grad_pkg::LAST_GRID && running |-> det_open && det_short;
    endproperty
    a_both_in_last: assert property (p_both_in_last) else $error("grid63 detects one");
endmodule : led_gradation_fault_control

// ==== led_host_model.sv ====
`timescale 1ns/10ps
module led_host_model (
    // clock
    input wire logic clk_sys,
    // register port toward the device
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // requested channel states
    output logic [23:0] chan_on
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chan_on = 24'h000000;
    end

    // entered at a falling edge; one idle cycle after each pulse keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n = 0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
        // idle cycle so a following read does not re-raise the strobe in the same step
        @(negedge clk_sys);
    endtask : rd

    // host drives the requested channel states as given
    task automatic set_on(input logic [23:0] v);
        chan_on = v;
    endtask : set_on
endmodule : led_host_model

// ==== led_gradation_fault_control_test.sv ====
`timescale 1ns/10ps
module led_gradation_fault_control_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, grid_group_level;
    logic reg_wr, reg_rd, reg_rvalid, sequence_active, thermal_trip_flag;
    logic [23:0] chan_on, led_enable;
    logic [23:0] open_cmp = 24'h000000;
    logic [23:0] short_cmp = 24'h000000;
    logic thermal_trip_flag_cmp = 1'b0;
    logic [5:0] grid_index;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    logic [7:0] durs [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h41};
    logic [23:0] steps [5] = '{24'(led_grad_pkg::STEP_2U5_CYC), 24'(led_grad_pkg::STEP_5U_CYC),
        24'(led_grad_pkg::STEP_10U_CYC), 24'(led_grad_pkg::STEP_20U_CYC),
        24'(2 * led_grad_pkg::STEP_5U_CYC)};

    always #10 clk_sys = ~clk_sys;

    led_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .chan_on(chan_on));

    led_gradation_fault_control #(.NUM_CHANNELS(24), .NUM_GRIDS(64)) uut (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .chan_on(chan_on), .open_cmp(open_cmp), .short_cmp(short_cmp),
        .thermal_trip_flag_cmp(thermal_trip_flag_cmp), .led_enable(led_enable),
        .grid_group_level(grid_group_level), .grid_index(grid_index),
        .sequence_active(sequence_active), .thermal_trip_flag(thermal_trip_flag));

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_port(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask : cmp_port

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        cmp_byte(d, exp);
    endtask : chk_reg

    task automatic wait_cyc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : wait_cyc

    // bounded so a stuck sequencer shows up as a mismatch, not a hang
    task automatic wait_grid(input logic [5:0] g);
        int k = 0;
        while (grid_index !== g && k < 9000) begin
            @(negedge clk_sys);
            k++;
        end
    endtask : wait_grid

    // counts falling edges spent in grid 0 once the sequencer runs
    task automatic measure(output int c);
        int k = 0;
        c = 0;
        while (sequence_active !== 1'b1 && k < 8) begin
            @(negedge clk_sys);
            k++;
        end
        while (sequence_active === 1'b1 && grid_index === 6'h00 && c < 2000) begin
            c++;
            @(negedge clk_sys);
        end
    endtask : measure

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        wait_cyc(8);
        reset = 1'b0;
        for (int a = 2; a < 12; a++) begin
            chk_reg(8'(a), 8'h00);
        end
        $display("reset values done");
        host.wr(8'h08, 8'hC5);
        chk_reg(8'h08, 8'hC5);
        host.wr(8'h02, 8'hFF);
        chk_reg(8'h02, 8'h00);
        host.wr(8'h09, 8'h3F);
        chk_reg(8'h09, 8'h3F);
        cmp_port(24'(sequence_active), 24'h000000);
        host.wr(8'h09, 8'h00);
        host.wr(8'h20, 8'hA5);
        host.wr(8'h0A, 8'h80);
        host.wr(8'h20, 8'h3C);
        chk_reg(8'h20, 8'h3C);
        host.wr(8'h0A, 8'h40);
        chk_reg(8'h20, 8'hA5);
        host.wr(8'h0B, 8'h80);
        chk_reg(8'h20, 8'h00);
        host.wr(8'h20, 8'h11);
        host.wr(8'h0B, 8'h00);
        chk_reg(8'h20, 8'hA5);
        $display("registers done");
        host.wr(8'h09, 8'h80);
        wait_cyc(4);
        cmp_port(24'(grid_group_level), 24'h00003C);
        host.wr(8'h09, 8'h00);
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h08, durs[i]);
            host.wr(8'h09, 8'h80);
            measure(n);
            cmp_port(24'(n), steps[i]);
            host.wr(8'h09, 8'h00);
        end
        host.wr(8'h08, 8'h00);
        host.wr(8'h09, 8'h80);
        wait_grid(6'h3F);
        wait_cyc(300);
        cmp_port(24'(grid_index), 24'h00003F);
        cmp_port(24'(sequence_active), 24'h000001);
        host.wr(8'h09, 8'h00);
        cmp_port(24'(grid_index), 24'h000000);
        cmp_port(24'(sequence_active), 24'h000000);
        host.wr(8'h09, 8'hC0);
        wait_grid(6'h3F);
        wait_grid(6'h00);
        cmp_port({17'h0, sequence_active, grid_index}, 24'h000040);
        host.wr(8'h09, 8'h00);
        $display("sequencer done");
        host.set_on(24'h000025);
        short_cmp = 24'h000003;
        open_cmp = 24'h000022;
        wait_cyc(12);
        chk_reg(8'h02, 8'h01);
        short_cmp = 24'h000000;
        wait_cyc(12);
        chk_reg(8'h02, 8'h00);
        host.wr(8'h09, 8'h80);
        wait_cyc(20);
        chk_reg(8'h03, 8'h08);
        short_cmp = 24'h000004;
        wait_cyc(20);
        chk_reg(8'h02, 8'h00);
        wait_grid(6'h01);
        wait_cyc(20);
        chk_reg(8'h02, 8'h10);
        host.set_on(24'h000001);
        wait_cyc(12);
        chk_reg(8'h03, 8'h00);
        chk_reg(8'h02, 8'h00);
        host.wr(8'h09, 8'h00);
        $display("faults done");
        host.set_on(24'h00F00F);
        wait_cyc(4);
        thermal_trip_flag_cmp = 1'b1;
        wait_cyc(12);
        cmp_port(24'(thermal_trip_flag), 24'h000001);
        cmp_port(led_enable, 24'h000000);
        thermal_trip_flag_cmp = 1'b0;
        wait_cyc(12);
        cmp_port(24'(thermal_trip_flag), 24'h000000);
        cmp_port(led_enable, 24'h00F00F);
        $display("thermal done");
        report_and_stop();
    end
endmodule : led_gradation_fault_control_test
